//--- dv/rbt_bus_model.sv
// far side bus logic that drives each data side when the transceiver does not
`timescale 1ns/100ps
module rbt_bus_model
(
  // clock
  input wire pclk,
  // far side drive requests
  input wire [1:0][17:0] val,
  input wire [1:0] drv,
  // transceiver pins
  input wire [17:0] a_out,
  input wire a_oe,
  input wire [17:0] b_out,
  input wire b_oe,
  // resolved bus levels
  output wire [17:0] a_in,
  output wire [17:0] b_in
);
  reg [17:0] a_last = 18'h00000;
  reg [17:0] b_last = 18'h00000;
  // a released bus has no pull, so it shows a changing pattern
  assign a_in = a_oe ? a_out : drv[0] ? val[0] : ~a_last;
  assign b_in = b_oe ? b_out : drv[1] ? val[1] : ~b_last;
  // last resolved level of each side
  always @(posedge pclk)
  begin
    a_last <= a_in;
    b_last <= b_in;
  end
endmodule // rbt_bus_model

//--- dv/rbt_transceiver_props.sv
// concurrent checks on the transceiver top module ports
`timescale 1ns/100ps
module rbt_transceiver_props
(
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // path controls
  input wire fwd_output_enable_n,
  input wire rev_output_enable_n,
  input wire fwd_latch_enable,
  input wire rev_latch_enable,
  input wire fwd_clock,
  input wire fwd_clock_enable_n,
  input wire rev_clock_enable_n,
  // data pins
  input wire [17:0] first_side_data_in,
  input wire [17:0] first_side_data_out,
  input wire first_side_data_oe,
  input wire [17:0] second_side_data_in,
  input wire [17:0] second_side_data_out,
  input wire second_side_data_oe
);
  reg [1:0] age;
  // edges since reset release, saturating at three
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // qualified forward clock rise, then a quiet capture window
  sequence fwd_rise;
    !fwd_clock ##1 fwd_clock && !fwd_clock_enable_n && !fwd_latch_enable;
  endsequence
  sequence fwd_quiet;
    (!fwd_latch_enable && !fwd_clock_enable_n && $stable(first_side_data_in))[*3];
  endsequence
  a_reset_outs_off:
    assert property ($rose(presetn) |-> !first_side_data_oe && !second_side_data_oe
      && first_side_data_out == 18'h0 && second_side_data_out == 18'h0) else $error("not off");
  a_fwd_oe_lag:
    assert property (age == 2'h3 |-> second_side_data_oe == !$past(fwd_output_enable_n, 3))
      else $error("fwd oe");
  a_rev_oe_lag:
    assert property (age == 2'h3 |-> first_side_data_oe == !$past(rev_output_enable_n, 3))
      else $error("rev oe");
  a_fwd_flow_thru:
    assert property (age == 2'h3 && $past(fwd_latch_enable, 3) && $past(fwd_latch_enable, 2)
      && $past(fwd_latch_enable) |-> second_side_data_out == $past(first_side_data_in, 3))
      else $error("fwd flow");
  a_rev_flow_thru:
    assert property (age == 2'h3 && $past(rev_latch_enable, 3) && $past(rev_latch_enable, 2)
      && $past(rev_latch_enable) |-> first_side_data_out == $past(second_side_data_in, 3))
      else $error("rev flow");
  a_fwd_clk_capture:
    assert property (fwd_rise ##1 fwd_quiet |=> second_side_data_out == $past(first_side_data_in))
      else $error("fwd capture");
  a_fwd_clk_inhibit:
    assert property ((!fwd_latch_enable && fwd_clock_enable_n)[*7] |-> $stable(second_side_data_out))
      else $error("fwd inhibit");
  a_rev_clk_inhibit:
    assert property ((!rev_latch_enable && rev_clock_enable_n)[*7] |-> $stable(first_side_data_out))
      else $error("rev inhibit");
  a_apb_err_map:
    assert property (psel && penable |-> pready
      && pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})) else $error("apb map");
  a_apb_rdata_idle:
    assert property (!(psel && penable) |-> prdata == 32'h0) else $error("idle rdata");
endmodule // rbt_transceiver_props
bind rbt_transceiver rbt_transceiver_props props_u (.*);

//--- dv/registered_bus_transceiver_tb.sv
// self-checking bench for the registered bus transceiver
`timescale 1ns/100ps
module registered_bus_transceiver_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rd;
  reg [1:0] oe_n = 2'h3, le = 2'h0, ce_n = 2'h3, ck = 2'h0, drv = 2'h0;
  reg [1:0][17:0] val = '0;
  wire pready, pslverr, a_oe, b_oe;
  wire [31:0] prdata;
  wire [17:0] a_out, b_out, a_in, b_in;
  integer errors = 0, check_count = 0, cyc = 0;
  rbt_transceiver dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .fwd_output_enable_n(oe_n[0]), .fwd_latch_enable(le[0]),
    .fwd_clock(ck[0]), .fwd_clock_enable_n(ce_n[0]), .rev_output_enable_n(oe_n[1]),
    .rev_latch_enable(le[1]), .rev_clock(ck[1]), .rev_clock_enable_n(ce_n[1]),
    .first_side_data_in(a_in), .first_side_data_out(a_out), .first_side_data_oe(a_oe),
    .second_side_data_in(b_in), .second_side_data_out(b_out), .second_side_data_oe(b_oe));
  rbt_bus_model bus_u (.pclk(pclk), .val(val), .drv(drv), .a_out(a_out), .a_oe(a_oe),
    .b_out(b_out), .b_oe(b_oe), .a_in(a_in), .b_in(b_in));
  // clock, 25 ns period
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  task wt(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  // one apb transfer, result left in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task pulse(input integer p);
    ck[p] <= 1'b1;
    wt(3);
    ck[p] <= 1'b0;
    wt(3);
  endtask
  task t_reset;
    chk("oe", 0, {a_oe, b_oe});
    chk("out", 0, b_out);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 0, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("hold", 0, rd);
    $display("reset test done");
  endtask
  task t_path(input integer p, input logic [17:0] v);
    logic [17:0] nv;
    nv = ~v;
    oe_n[p] <= 1'b0;
    val[p] <= v;
    drv[p] <= 1'b1;
    le[p] <= 1'b1;
    wt(5);
    chk("oe on", 1, p ? a_oe : b_oe);
    chk("flow", v, p ? a_out : b_out);
    le[p] <= 1'b0;
    ce_n[p] <= 1'b0;
    wt(3);
    val[p] <= nv;
    wt(5);
    chk("held", v, p ? a_out : b_out);
    pulse(p);
    chk("capture", nv, p ? a_out : b_out);
    ce_n[p] <= 1'b1;
    val[p] <= v;
    wt(3);
    pulse(p);
    chk("inhibit", nv, p ? a_out : b_out);
    oe_n[p] <= 1'b1;
    drv[p] <= 1'b0;
    wt(5);
    chk("oe off", 0, p ? a_oe : b_oe);
    $display("path %0d test done", p);
  endtask
  // reverse captures fill the log until it refuses, then drain it
  task t_log;
    integer i;
    apb(1'b1, 8'h00, 32'h3);
    drv[1] <= 1'b1;
    ce_n[1] <= 1'b0;
    for (i = 0; i < 5; i++)
    begin
      val[1] <= 18'h00100 + i[17:0];
      wt(3);
      pulse(1);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h0f, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("rev hold", 32'h103, rd);
    for (i = 0; i <= 4; i++)
    begin
      apb(1'b0, 8'h08, 32'h0);
      chk("log", i < 4 ? 32'h100 + i : 0, rd);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h0c, rd);
    apb(1'b1, 8'h20, 32'h0);
    chk("slverr", 1, err);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h3, rd);
    $display("log test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    wt(8);
    presetn <= 1'b1;
    wt(1);
    t_reset;
    t_path(0, 18'h2a5c3);
    t_path(1, 18'h1c3a5);
    t_log;
    print_verdict;
  end
endmodule // registered_bus_transceiver_tb

//--- rtl/rbt_defines.vh
// constants shared by the registered bus transceiver files
`ifndef RBT_DEFINES_VH
`define RBT_DEFINES_VH

// ----------------------------------------
// data path geometry
// ----------------------------------------
`define RBT_DATA_W 18
`define RBT_FIFO_DEPTH 4
`define RBT_STORE_RESET 18'h00000
`define RBT_FIFO_PTR_W 2

// ----------------------------------------
// packed control pin positions
// ----------------------------------------
`define RBT_CTL_CE_N 0
`define RBT_CTL_CLK 1
`define RBT_CTL_LE 2
`define RBT_CTL_OE_N 3
`define RBT_CTL_REV 4
`define RBT_CTL_IDLE 8'h88

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define RBT_ADDR_W 8
`define RBT_OFS_CTRL 8'h00
`define RBT_OFS_STATUS 8'h04
`define RBT_OFS_LOG 8'h08
`define RBT_OFS_FWD_HOLD 8'h0c
`define RBT_OFS_REV_HOLD 8'h10

// ----------------------------------------
// control register fields
// ----------------------------------------
`define RBT_CTRL_W 2
`define RBT_CTRL_RESET 2'h0
`define RBT_CTRL_LOG_EN 0
`define RBT_CTRL_LOG_SRC 1

// ----------------------------------------
// status register fields
// ----------------------------------------
`define RBT_ST_NOT_EMPTY 0
`define RBT_ST_FULL 1
`define RBT_ST_FWD_OE_N 2
`define RBT_ST_REV_OE_N 3
`define RBT_ST_FWD_LE 4
`define RBT_ST_REV_LE 5
`define RBT_ST_BOTH_ON 6
`define RBT_ST_W 7

`endif

//--- rtl/rbt_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module rbt_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 4,
  parameter PTR_W = 2
)
(
  // clock and reset
  input wire pclk,
  input wire presetn,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data,
  // fill level
  output reg [PTR_W:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  wire push;
  wire pop;
  integer i;

  // honest full and empty from the level count
  assign in_ready = ({{(31-PTR_W){1'b0}}, level} != DEPTH);
  assign out_valid = (level != {(PTR_W+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers, level and storage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      level <= {(PTR_W+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        level <= level + 1'b1;
      else if (pop && !push)
        level <= level - 1'b1;
    end
  end

  // head word, read combinationally from storage
  always @*
  begin
    out_data = mem[rd_ptr];
  end

endmodule // rbt_fifo

//--- rtl/rbt_transceiver.v
// registered 18-bit bidirectional bus transceiver with apb status port
//
// Operation
// - 18 bits pass each way unchanged; outputs have high, low and off states.
// - latch enable high: forward input flows straight to second side outputs.
// - latch enable low, clock steady: stored word held, input changes ignored.
// - latch enable low, clock enable low: capture input on clock rising edge; a full log in lockstep mode blocks capture on the logged path.
// - output enable low drives outputs; high puts them off regardless.
// - clock enable high with latch enable low: clock edges ignored, word held.
// - falling clock never captures; held value follows past rising edges only.
// - reverse path mirrors forward path with its own four controls.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "rbt_defines.vh"
module rbt_transceiver
(
  // system clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`RBT_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // forward path controls
  input wire fwd_output_enable_n,
  input wire fwd_latch_enable,
  input wire fwd_clock,
  input wire fwd_clock_enable_n,
  // reverse path controls
  input wire rev_output_enable_n,
  input wire rev_latch_enable,
  input wire rev_clock,
  input wire rev_clock_enable_n,
  // first side bus pins
  input wire [`RBT_DATA_W-1:0] first_side_data_in,
  output reg [`RBT_DATA_W-1:0] first_side_data_out,
  output reg first_side_data_oe,
  // second side bus pins
  input wire [`RBT_DATA_W-1:0] second_side_data_in,
  output reg [`RBT_DATA_W-1:0] second_side_data_out,
  output reg second_side_data_oe
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------

  // control bits packed: [3]=oe_n [2]=le [1]=clk [0]=ce_n, fwd low nibble
  wire [7:0] ctl_pins;
  reg [7:0] ctl_meta;
  reg [7:0] ctl_sync;
  reg [1:0] clk_prev;
  reg [`RBT_DATA_W-1:0] fwd_din_meta;
  reg [`RBT_DATA_W-1:0] fwd_din_sync;
  reg [`RBT_DATA_W-1:0] rev_din_meta;
  reg [`RBT_DATA_W-1:0] rev_din_sync;

  // reverse controls in the high nibble
  assign ctl_pins[7:4] = {rev_output_enable_n, rev_latch_enable, rev_clock, rev_clock_enable_n};
  // forward controls in the low nibble
  assign ctl_pins[3:0] = {fwd_output_enable_n, fwd_latch_enable, fwd_clock, fwd_clock_enable_n};

  // two flops on every control pin; oe_n settles high so outputs start off
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_meta <= `RBT_CTL_IDLE;
      ctl_sync <= `RBT_CTL_IDLE;
    end
    else
    begin
      ctl_meta <= ctl_pins;
      ctl_sync <= ctl_meta;
    end
  end

  // two flops on the first side data pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_din_meta <= `RBT_STORE_RESET;
      fwd_din_sync <= `RBT_STORE_RESET;
    end
    else
    begin
      fwd_din_meta <= first_side_data_in;
      fwd_din_sync <= fwd_din_meta;
    end
  end

  // two flops on the second side data pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rev_din_meta <= `RBT_STORE_RESET;
      rev_din_sync <= `RBT_STORE_RESET;
    end
    else
    begin
      rev_din_meta <= second_side_data_in;
      rev_din_sync <= rev_din_meta;
    end
  end

  // ----------------------------------------
  // per path decode
  // ----------------------------------------

  wire [1:0] oe_n_s;
  wire [1:0] le_s;
  wire [1:0] clk_s;
  wire [1:0] ce_n_s;
  wire [1:0] clk_rise;

  // output enable per path, forward in bit 0
  assign oe_n_s[0] = ctl_sync[`RBT_CTL_OE_N];
  assign oe_n_s[1] = ctl_sync[`RBT_CTL_REV + `RBT_CTL_OE_N];
  // latch enable per path
  assign le_s[0] = ctl_sync[`RBT_CTL_LE];
  assign le_s[1] = ctl_sync[`RBT_CTL_REV + `RBT_CTL_LE];
  // path clock level per path
  assign clk_s[0] = ctl_sync[`RBT_CTL_CLK];
  assign clk_s[1] = ctl_sync[`RBT_CTL_REV + `RBT_CTL_CLK];
  // clock enable per path
  assign ce_n_s[0] = ctl_sync[`RBT_CTL_CE_N];
  assign ce_n_s[1] = ctl_sync[`RBT_CTL_REV + `RBT_CTL_CE_N];

  // rising edge only; a fall or a steady level never captures
  assign clk_rise = clk_s & ~clk_prev;

  // previous clock level, taken from the second flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_prev <= 2'h0;
    else
      clk_prev <= clk_s;
  end

  // ----------------------------------------
  // control and capture log
  // ----------------------------------------

  reg [`RBT_CTRL_W-1:0] ctrl;
  wire log_en;
  wire log_src;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [`RBT_DATA_W-1:0] fifo_out_data;
  wire [1:0] clocked_capture;
  wire [1:0] log_stall;
  wire log_push;
  wire [`RBT_DATA_W-1:0] log_word;

  assign log_en = ctrl[`RBT_CTRL_LOG_EN];
  assign log_src = ctrl[`RBT_CTRL_LOG_SRC];

  // lockstep mode: a full log holds back clocked storage on the logged path
  assign log_stall[0] = log_en & ~log_src & ~fifo_in_ready;
  assign log_stall[1] = log_en & log_src & ~fifo_in_ready;

  // clocked storage only with latch closed and clock enable low
  assign clocked_capture = ~le_s & ~ce_n_s & clk_rise & ~log_stall;

  // every clocked capture of the selected path is offered to the log
  assign log_push = log_en & (log_src ? clocked_capture[1] : clocked_capture[0]);
  assign log_word = log_src ? rev_din_sync : fwd_din_sync;

  // ----------------------------------------
  // capture log fifo
  // ----------------------------------------

  // fill level not needed, full and empty come from the handshakes
  rbt_fifo #(
    .WIDTH(`RBT_DATA_W),
    .DEPTH(`RBT_FIFO_DEPTH),
    .PTR_W(`RBT_FIFO_PTR_W)
  ) u_log_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(log_push),
    .in_ready(fifo_in_ready),
    .in_data(log_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level()
  );

  // ----------------------------------------
  // storage elements
  // ----------------------------------------

  reg [`RBT_DATA_W-1:0] fwd_store;
  reg [`RBT_DATA_W-1:0] rev_store;
  reg [`RBT_DATA_W-1:0] next_fwd_store;
  reg [`RBT_DATA_W-1:0] next_rev_store;

  // forward next value: transparent, clocked, or held
  always @*
  begin
    if (le_s[0])
      next_fwd_store = fwd_din_sync;
    else if (clocked_capture[0])
      next_fwd_store = fwd_din_sync;
    else
      next_fwd_store = fwd_store;
  end

  // forward store register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fwd_store <= `RBT_STORE_RESET;
    else
      fwd_store <= next_fwd_store;
  end

  // reverse next value, same scheme on its own controls
  always @*
  begin
    if (le_s[1])
      next_rev_store = rev_din_sync;
    else if (clocked_capture[1])
      next_rev_store = rev_din_sync;
    else
      next_rev_store = rev_store;
  end

  // reverse store register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rev_store <= `RBT_STORE_RESET;
    else
      rev_store <= next_rev_store;
  end

  // ----------------------------------------
  // output drivers
  // ----------------------------------------

  // second side drivers from flops, bits passed without inversion
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      second_side_data_out <= `RBT_STORE_RESET;
      second_side_data_oe <= 1'b0;
    end
    else
    begin
      // transparent data bypasses the store so it is not one cycle late
      second_side_data_out <= le_s[0] ? fwd_din_sync : fwd_store;
      second_side_data_oe <= ~oe_n_s[0];
    end
  end

  // first side drivers, mirror of the second side
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_side_data_out <= `RBT_STORE_RESET;
      first_side_data_oe <= 1'b0;
    end
    else
    begin
      first_side_data_out <= le_s[1] ? rev_din_sync : rev_store;
      first_side_data_oe <= ~oe_n_s[1];
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------

  wire access;
  wire rd_access;
  wire wr_access;
  reg addr_hit;
  reg [31:0] next_prdata;
  wire [`RBT_ST_W-1:0] status;

  // zero wait states: every access completes in its first access cycle
  assign access = psel & penable;
  assign rd_access = access & ~pwrite;
  assign wr_access = access & pwrite;
  assign pready = 1'b1;
  assign pslverr = access & ~addr_hit;

  // a read of the log word pops it
  assign fifo_out_ready = rd_access & (paddr == `RBT_OFS_LOG);

  // both directions enabled is only reported, never blocked
  assign status[`RBT_ST_BOTH_ON] = ~oe_n_s[0] & ~oe_n_s[1];
  assign status[`RBT_ST_REV_LE] = le_s[1];
  assign status[`RBT_ST_FWD_LE] = le_s[0];
  assign status[`RBT_ST_REV_OE_N] = oe_n_s[1];
  assign status[`RBT_ST_FWD_OE_N] = oe_n_s[0];
  assign status[`RBT_ST_FULL] = ~fifo_in_ready;
  assign status[`RBT_ST_NOT_EMPTY] = fifo_out_valid;

  // address decode and read mux
  always @*
  begin
    addr_hit = 1'b1;
    next_prdata = 32'h00000000;
    case (paddr)
      `RBT_OFS_CTRL:
        next_prdata = {{(32-`RBT_CTRL_W){1'b0}}, ctrl};
      `RBT_OFS_STATUS:
        next_prdata = {{(32-`RBT_ST_W){1'b0}}, status};
      `RBT_OFS_LOG:
        next_prdata = fifo_out_valid ? {{(32-`RBT_DATA_W){1'b0}}, fifo_out_data} : 32'h00000000;
      `RBT_OFS_FWD_HOLD:
        next_prdata = {{(32-`RBT_DATA_W){1'b0}}, fwd_store};
      `RBT_OFS_REV_HOLD:
        next_prdata = {{(32-`RBT_DATA_W){1'b0}}, rev_store};
      default:
        addr_hit = 1'b0;
    endcase
  end

  // read data valid during the access cycle
  always @*
  begin
    prdata = rd_access ? next_prdata : 32'h00000000;
  end

  // control register write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `RBT_CTRL_RESET;
    else if (wr_access && paddr == `RBT_OFS_CTRL)
      ctrl <= pwdata[`RBT_CTRL_W-1:0];
  end

endmodule // rbt_transceiver
